// ### hw/sdcbs_cfg.svh
// Addresses, field positions, reset values and timing counts of the card/buffer status block
`ifndef SDCBS_CFG_SVH
`define SDCBS_CFG_SVH
`define SDCBS_ADDR_W 8
`define SDCBS_CTRL_ADDR 8'h00
`define SDCBS_GAP_ADDR 8'h04
`define SDCBS_STATE_ADDR 8'h24
`define SDCBS_ISTAT_ADDR 8'h30
`define SDCBS_IMASK_ADDR 8'h34
`define SDCBS_PS_DET_BIT 18
`define SDCBS_PS_STABLE_BIT 17
`define SDCBS_PS_INS_BIT 16
`define SDCBS_PS_RDRDY_BIT 11
`define SDCBS_PS_BWR_BIT 10
`define SDCBS_PS_RDBUSY_BIT 9
`define SDCBS_PS_DLB_BIT 2
`define SDCBS_PS_INHIBIT_BIT 1
`define SDCBS_CTRL_PWR_BIT 0
`define SDCBS_CTRL_CLK_BIT 1
`define SDCBS_CTRL_SRST_BIT 2
`define SDCBS_GAP_STOP_BIT 0
`define SDCBS_GAP_CONT_BIT 1
`define SDCBS_IRQ_W 5
`define SDCBS_IRQ_RST 5'h00
`define SDCBS_DATA_RST 32'h0000_0000
`define SDCBS_RESP_OKAY 2'h0
`define SDCBS_RESP_SLVERR 2'h2
`define SDCBS_DEB_TIME_NS 100000
`define SDCBS_CLK_MHZ 25
`define SDCBS_DEB_CYC ((`SDCBS_DEB_TIME_NS * `SDCBS_CLK_MHZ) / 1000)
`define SDCBS_DEB_CNT_W 12
`endif

// ### hw/sdcbs_debounce.sv
// Card detect pin synchroniser and debounce filter
`timescale 1ns/1ps
`include "sdcbs_cfg.svh"

module sdcbs_debounce (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_n_i,
  output logic card_detect_o,
  output logic stable_o,
  output logic inserted_o
);
  logic sync1_ff;
  logic sync2_ff;
  logic last_ff;
  logic [`SDCBS_DEB_CNT_W-1:0] cnt_ff;
  logic [`SDCBS_DEB_CNT_W-1:0] nxt_cnt;
  logic stable_ff;
  logic nxt_stable;
  logic ins_ff;
  logic nxt_ins;
  logic det_ff;
  logic chg_w;
  logic reached_w;

  // Any level change restarts the settle interval
  assign chg_w = sync2_ff != last_ff;
  assign reached_w = cnt_ff == `SDCBS_DEB_CNT_W'(`SDCBS_DEB_CYC - 1);
  assign nxt_cnt = chg_w ? '0 : (reached_w ? cnt_ff : cnt_ff + `SDCBS_DEB_CNT_W'(1));
  assign nxt_stable = chg_w ? 1'b0 : (reached_w ? 1'b1 : stable_ff);
  assign nxt_ins = chg_w ? 1'b0 : (reached_w ? ~sync2_ff : ins_ff);
  assign card_detect_o = det_ff;
  assign stable_o = stable_ff;
  assign inserted_o = ins_ff;

  // Pin resets to the empty-socket level; no software reset reaches here
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      last_ff <= 1'b1;
      cnt_ff <= '0;
      stable_ff <= 1'b0;
      ins_ff <= 1'b0;
      det_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_n_i;
      sync2_ff <= sync1_ff;
      last_ff <= sync2_ff;
      cnt_ff <= nxt_cnt;
      stable_ff <= nxt_stable;
      ins_ff <= nxt_ins;
      det_ff <= ~sync2_ff;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_change_unstable;
    chg_w |=> !stable_ff && !ins_ff;
  endproperty
  a_change_unstable: assert property (p_change_unstable)
    else $error("detect flags survived a pin change");

  property p_det_inverse;
    ##1 det_ff == !$past(sync2_ff);
  endproperty
  a_det_inverse: assert property (p_det_inverse)
    else $error("card detect is not the inverted pin");

  property p_settle_time;
    $rose(stable_ff) |-> cnt_ff == `SDCBS_DEB_CNT_W'(`SDCBS_DEB_CYC - 1);
  endproperty
  a_settle_time: assert property (p_settle_time)
    else $error("stable flag rose before the full settle interval");

endmodule

// ### hw/sdcbs_pkg.sv
// Types shared by the card/buffer status block
package sdcbs_pkg;

  // Sticky interrupt sources; status and mask share this layout
  typedef struct packed {
    logic xfer_done;
    logic wr_ready;
    logic rd_ready;
    logic removal;
    logic insertion;
  } sdcbs_irq_t;

  // Bus shutdown sequence after a live card removal
  typedef enum logic [1:0] {
    SDCBS_SHUT_IDLE = 2'b01,
    SDCBS_SHUT_RST_CLR = 2'b10
  } sdcbs_shut_t;

endpackage

// ### hw/sdcbs_top.sv
// Card detect and buffer/transfer status block with AXI4-Lite register slave
//
// Summary of operation
// - Bit 18 of the present state reads 1 when the detect pin is low and 0 when it is high.
// - Bit 17 shows that the detect pin has settled at either level and ignores software reset.
// - Bit 16 rising raises an insertion interrupt, falling a removal one; software reset leaves it.
// - The inserted flag is 0 in reset, while debouncing or with no card, and 1 only with a card in.
// - Card detection keeps working whatever the state of card bus power.
// - A removal with power and clock on clears both controls, and then the full software reset.
// - Bit 11 sets with an interrupt when a whole block waits in the buffer and clears once read out.
// - Bit 10 sets with an interrupt when a block may start to be written and clears once written.
// - Bit 9 sets on a read command end bit or on a continue request for block gaps.
// - Bit 9 clears after the last block, or after all blocks are out following a gap stop.
// - Bit 9 falling raises a transfer complete interrupt.
// - The data inhibit flag follows data line busy or read busy, and its fall sets transfer complete.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdcbs_cfg.svh"

module sdcbs_top (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [`SDCBS_ADDR_W-1:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [`SDCBS_ADDR_W-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic CARD_DETECT_PIN_N_I,
  input wire logic XFER_RD_CMD_END_I,
  input wire logic XFER_LAST_BLOCK_I,
  input wire logic XFER_GAP_IDLE_I,
  input wire logic DATA_LINE_BUSY_I,
  input wire logic BUF_RD_FULL_I,
  input wire logic BUF_RD_DRAINED_I,
  input wire logic BUF_WR_SPACE_I,
  input wire logic BUF_WR_FILLED_I,
  output logic CARD_BUS_POWER_O,
  output logic CARD_CLOCK_EN_O,
  output logic FULL_SW_RESET_O,
  output logic DATA_CMD_INHIBIT_O,
  output logic IRQ_O
);
  import sdcbs_pkg::*;

  logic det_w;
  logic stable_w;
  logic ins_w;
  logic ins_prev_ff;
  logic ins_ev_w;
  logic rem_ev_w;
  logic aw_hold_ff;
  logic [`SDCBS_ADDR_W-1:0] aw_addr_ff;
  logic w_hold_ff;
  logic [31:0] w_data_ff;
  logic w_lane0_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_fire_w;
  logic w_fire_w;
  logic wr_fire_w;
  logic ar_fire_w;
  logic nxt_aw_hold;
  logic nxt_w_hold;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic wr_ok_w;
  logic wr_ctrl_w;
  logic wr_gap_w;
  logic wr_mask_w;
  logic rd_hit_w;
  logic rd_stat_w;
  logic [31:0] rd_val_w;
  logic pwr_ff;
  logic clk_en_ff;
  logic srst_ff;
  logic nxt_pwr;
  logic nxt_clk_en;
  logic nxt_srst;
  logic stop_ff;
  logic nxt_stop;
  logic cont_w;
  sdcbs_shut_t shut_ff;
  sdcbs_shut_t nxt_shut;
  logic shut_cut_w;
  logic rd_rdy_ff;
  logic bwr_ff;
  logic rd_busy_ff;
  logic inhibit_ff;
  logic dlb_ff;
  logic nxt_rd_rdy;
  logic nxt_bwr;
  logic nxt_rd_busy;
  logic busy_set_w;
  logic busy_clr_w;
  sdcbs_irq_t stat_ff;
  sdcbs_irq_t mask_ff;
  sdcbs_irq_t ev_w;
  sdcbs_irq_t nxt_stat;
  logic irq_ff;
  logic [31:0] state_img_w;
  logic [31:0] ctrl_w;
  logic [31:0] gap_w;

  // Detect path runs on its own reset only, so bus power never gates it
  sdcbs_debounce u_debounce (
    .clk_i(REF_CLK_I),
    .reset_n_i(RESET_N_I),
    .pin_n_i(CARD_DETECT_PIN_N_I),
    .card_detect_o(det_w),
    .stable_o(stable_w),
    .inserted_o(ins_w)
  );

  // Edges of the inserted flag become interrupt events
  assign ins_ev_w = ins_w & ~ins_prev_ff;
  assign rem_ev_w = ~ins_w & ins_prev_ff;

  // Write channel: address and data taken in either order, response after both
  assign aw_fire_w = AXI_AWVALID_I & awready_ff;
  assign w_fire_w = AXI_WVALID_I & wready_ff;
  assign wr_fire_w = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign nxt_aw_hold = aw_hold_ff ? ~wr_fire_w : aw_fire_w;
  assign nxt_w_hold = w_hold_ff ? ~wr_fire_w : w_fire_w;
  assign nxt_bvalid = bvalid_ff ? ~AXI_BREADY_I : wr_fire_w;
  assign wr_ok_w = (aw_addr_ff == `SDCBS_CTRL_ADDR) | (aw_addr_ff == `SDCBS_GAP_ADDR) |
                   (aw_addr_ff == `SDCBS_IMASK_ADDR);
  assign wr_ctrl_w = wr_fire_w & w_lane0_ff & (aw_addr_ff == `SDCBS_CTRL_ADDR);
  assign wr_gap_w = wr_fire_w & w_lane0_ff & (aw_addr_ff == `SDCBS_GAP_ADDR);
  assign wr_mask_w = wr_fire_w & w_lane0_ff & (aw_addr_ff == `SDCBS_IMASK_ADDR);

  // Read channel: one read at a time, data one cycle after the address
  assign ar_fire_w = AXI_ARVALID_I & arready_ff;
  assign nxt_rvalid = rvalid_ff ? ~AXI_RREADY_I : ar_fire_w;
  assign rd_stat_w = ar_fire_w & (AXI_ARADDR_I == `SDCBS_ISTAT_ADDR);
  assign rd_hit_w = (AXI_ARADDR_I == `SDCBS_CTRL_ADDR) | (AXI_ARADDR_I == `SDCBS_GAP_ADDR) |
                    (AXI_ARADDR_I == `SDCBS_STATE_ADDR) |
                    (AXI_ARADDR_I == `SDCBS_ISTAT_ADDR) | (AXI_ARADDR_I == `SDCBS_IMASK_ADDR);

  // Register images; unlisted bits read as zero
  assign state_img_w = (32'(det_w) << `SDCBS_PS_DET_BIT) |
                       (32'(stable_w) << `SDCBS_PS_STABLE_BIT) |
                       (32'(ins_w) << `SDCBS_PS_INS_BIT) |
                       (32'(rd_rdy_ff) << `SDCBS_PS_RDRDY_BIT) |
                       (32'(bwr_ff) << `SDCBS_PS_BWR_BIT) |
                       (32'(rd_busy_ff) << `SDCBS_PS_RDBUSY_BIT) |
                       (32'(dlb_ff) << `SDCBS_PS_DLB_BIT) |
                       (32'(inhibit_ff) << `SDCBS_PS_INHIBIT_BIT);
  assign ctrl_w = (32'(pwr_ff) << `SDCBS_CTRL_PWR_BIT) | (32'(clk_en_ff) << `SDCBS_CTRL_CLK_BIT) |
                  (32'(srst_ff) << `SDCBS_CTRL_SRST_BIT);
  assign gap_w = 32'(stop_ff) << `SDCBS_GAP_STOP_BIT;
  assign rd_val_w = (AXI_ARADDR_I == `SDCBS_CTRL_ADDR) ? ctrl_w :
                    (AXI_ARADDR_I == `SDCBS_GAP_ADDR) ? gap_w :
                    (AXI_ARADDR_I == `SDCBS_STATE_ADDR) ? state_img_w :
                    (AXI_ARADDR_I == `SDCBS_ISTAT_ADDR) ? 32'(stat_ff) :
                    (AXI_ARADDR_I == `SDCBS_IMASK_ADDR) ? 32'(mask_ff) : `SDCBS_DATA_RST;

  // Bus controls; a live removal overrides a software write in the same cycle
  assign shut_cut_w = rem_ev_w & pwr_ff & clk_en_ff;
  assign nxt_pwr = shut_cut_w ? 1'b0 : (wr_ctrl_w ? w_data_ff[`SDCBS_CTRL_PWR_BIT] : pwr_ff);
  assign nxt_clk_en = shut_cut_w ? 1'b0 :
                      (wr_ctrl_w ? w_data_ff[`SDCBS_CTRL_CLK_BIT] : clk_en_ff);
  assign nxt_srst = (shut_ff == SDCBS_SHUT_RST_CLR) ? 1'b0 :
                    (wr_ctrl_w ? w_data_ff[`SDCBS_CTRL_SRST_BIT] : srst_ff);

  // Shutdown sequencer: cut the bus first, clear the full reset one cycle later
  always_comb begin
    case (shut_ff)
      SDCBS_SHUT_IDLE: nxt_shut = shut_cut_w ? SDCBS_SHUT_RST_CLR : SDCBS_SHUT_IDLE;
      SDCBS_SHUT_RST_CLR: nxt_shut = SDCBS_SHUT_IDLE;
      default: nxt_shut = SDCBS_SHUT_IDLE;
    endcase
  end

  // Block gap: stop is a level, continue is a write-one pulse that reads zero
  assign nxt_stop = srst_ff ? 1'b0 : (wr_gap_w ? w_data_ff[`SDCBS_GAP_STOP_BIT] : stop_ff);
  assign cont_w = wr_gap_w & w_data_ff[`SDCBS_GAP_CONT_BIT];

  // Buffer and transfer flags; a set always beats a clear in the same cycle
  assign nxt_rd_rdy = BUF_RD_FULL_I | (rd_rdy_ff & ~BUF_RD_DRAINED_I & ~srst_ff);
  assign nxt_bwr = BUF_WR_SPACE_I | (bwr_ff & ~BUF_WR_FILLED_I & ~srst_ff);
  assign busy_set_w = XFER_RD_CMD_END_I | cont_w;
  assign busy_clr_w = XFER_LAST_BLOCK_I | (stop_ff & XFER_GAP_IDLE_I) | srst_ff;
  assign nxt_rd_busy = busy_set_w | (rd_busy_ff & ~busy_clr_w);

  // Interrupt events; a read clears status but a fresh event survives it
  assign ev_w.insertion = ins_ev_w;
  assign ev_w.removal = rem_ev_w;
  assign ev_w.rd_ready = nxt_rd_rdy & ~rd_rdy_ff;
  assign ev_w.wr_ready = nxt_bwr & ~bwr_ff;
  assign ev_w.xfer_done = (rd_busy_ff & ~nxt_rd_busy) |
                          (inhibit_ff & ~(DATA_LINE_BUSY_I | rd_busy_ff));
  assign nxt_stat = (stat_ff & ~(rd_stat_w ? '1 : sdcbs_irq_t'(`SDCBS_IRQ_RST))) | ev_w;

  // Bus handshake flops
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold;
      wready_ff <= ~nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Bus payload flops; each moves only on its own handshake
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_addr_ff <= '0;
      w_data_ff <= `SDCBS_DATA_RST;
      w_lane0_ff <= 1'b0;
      bresp_ff <= `SDCBS_RESP_OKAY;
      rdata_ff <= `SDCBS_DATA_RST;
      rresp_ff <= `SDCBS_RESP_OKAY;
    end else begin
      if (aw_fire_w) aw_addr_ff <= AXI_AWADDR_I;
      if (w_fire_w) w_data_ff <= AXI_WDATA_I;
      if (w_fire_w) w_lane0_ff <= AXI_WSTRB_I[0];
      if (wr_fire_w) bresp_ff <= wr_ok_w ? `SDCBS_RESP_OKAY : `SDCBS_RESP_SLVERR;
      if (ar_fire_w) rdata_ff <= rd_val_w;
      if (ar_fire_w) rresp_ff <= rd_hit_w ? `SDCBS_RESP_OKAY : `SDCBS_RESP_SLVERR;
    end
  end

  // Control, status and interrupt state
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ins_prev_ff <= 1'b0;
      pwr_ff <= 1'b0;
      clk_en_ff <= 1'b0;
      srst_ff <= 1'b0;
      stop_ff <= 1'b0;
      shut_ff <= SDCBS_SHUT_IDLE;
      rd_rdy_ff <= 1'b0;
      bwr_ff <= 1'b0;
      rd_busy_ff <= 1'b0;
      inhibit_ff <= 1'b0;
      dlb_ff <= 1'b0;
      stat_ff <= `SDCBS_IRQ_RST;
      mask_ff <= `SDCBS_IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      ins_prev_ff <= ins_w;
      pwr_ff <= nxt_pwr;
      clk_en_ff <= nxt_clk_en;
      srst_ff <= nxt_srst;
      stop_ff <= nxt_stop;
      shut_ff <= nxt_shut;
      rd_rdy_ff <= nxt_rd_rdy;
      bwr_ff <= nxt_bwr;
      rd_busy_ff <= nxt_rd_busy;
      inhibit_ff <= DATA_LINE_BUSY_I | rd_busy_ff;
      dlb_ff <= DATA_LINE_BUSY_I;
      stat_ff <= nxt_stat;
      if (wr_mask_w) mask_ff <= w_data_ff[`SDCBS_IRQ_W-1:0];
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // Every output straight from a flop
  assign AXI_AWREADY_O = awready_ff;
  assign AXI_WREADY_O = wready_ff;
  assign AXI_BVALID_O = bvalid_ff;
  assign AXI_BRESP_O = bresp_ff;
  assign AXI_ARREADY_O = arready_ff;
  assign AXI_RVALID_O = rvalid_ff;
  assign AXI_RDATA_O = rdata_ff;
  assign AXI_RRESP_O = rresp_ff;
  assign CARD_BUS_POWER_O = pwr_ff;
  assign CARD_CLOCK_EN_O = clk_en_ff;
  assign FULL_SW_RESET_O = srst_ff;
  assign DATA_CMD_INHIBIT_O = inhibit_ff;
  assign IRQ_O = irq_ff;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_ins_implies_det;
    ins_w |-> det_w && stable_w;
  endproperty
  a_ins_implies_det: assert property (p_ins_implies_det)
    else $error("inserted flag set without a settled low pin");

  property p_ins_irq;
    $rose(ins_w) |=> stat_ff.insertion;
  endproperty
  a_ins_irq: assert property (p_ins_irq)
    else $error("insertion did not set its status bit");

  property p_rem_irq;
    $fell(ins_w) |=> stat_ff.removal;
  endproperty
  a_rem_irq: assert property (p_rem_irq)
    else $error("removal did not set its status bit");

  property p_shutdown;
    shut_cut_w |=> !pwr_ff && !clk_en_ff ##1 !srst_ff;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("live removal did not shut the bus down in order");

  property p_rd_rdy_irq;
    $rose(rd_rdy_ff) |-> stat_ff.rd_ready;
  endproperty
  a_rd_rdy_irq: assert property (p_rd_rdy_irq)
    else $error("read ready rise without its status bit");

  property p_rd_rdy_clear;
    rd_rdy_ff && BUF_RD_DRAINED_I && !BUF_RD_FULL_I |=> !rd_rdy_ff;
  endproperty
  a_rd_rdy_clear: assert property (p_rd_rdy_clear)
    else $error("read ready stayed set after the block was read out");

  property p_bwr_irq;
    $rose(bwr_ff) |-> stat_ff.wr_ready;
  endproperty
  a_bwr_irq: assert property (p_bwr_irq)
    else $error("write ready rise without its status bit");

  property p_busy_set;
    XFER_RD_CMD_END_I |=> rd_busy_ff ##1 inhibit_ff;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("read command end did not mark the transfer busy");

  property p_busy_clr;
    XFER_LAST_BLOCK_I && !busy_set_w |=> !rd_busy_ff;
  endproperty
  a_busy_clr: assert property (p_busy_clr)
    else $error("last block did not end the read transfer");

  property p_tc_irq;
    $fell(rd_busy_ff) |-> stat_ff.xfer_done;
  endproperty
  a_tc_irq: assert property (p_tc_irq)
    else $error("end of read transfer raised no completion");

  property p_inhibit;
    inhibit_ff == ($past(DATA_LINE_BUSY_I) || $past(rd_busy_ff));
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit flag does not follow its sources");

  c_insert: cover property ($rose(ins_w));
  c_shutdown: cover property (shut_cut_w ##2 !srst_ff);
  c_read_block: cover property ($rose(rd_rdy_ff) ##[1:20] $fell(rd_rdy_ff));
  c_irq: cover property ($rose(irq_ff));

endmodule

// ### tb/sdcbs_card_model.sv
// Socket model: card detect pin with contact chatter on insertion and removal
`timescale 1ns/1ps

module sdcbs_card_model (
  input wire logic clk_i,
  output logic pin_n_o
);
  // Empty socket at power up, pull-up holds the pin high
  initial pin_n_o = 1'b1;

  // Contacts chatter first; the settle wait outlasts the detect filter
  task automatic move(input logic lvl);
    for (int i = 0; i < 6; i++) begin
      repeat (3 + i) @(posedge clk_i);
      pin_n_o <= (i % 2 == 0) ? lvl : !lvl;
    end
    repeat (3) @(posedge clk_i);
    pin_n_o <= lvl;
    repeat (2600) @(posedge clk_i);
  endtask
endmodule

// ### tb/tb_sdcbs_top.sv
// Self-checking bench for the card detect and buffer/transfer status block
`timescale 1ns/1ps

module tb_sdcbs_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [6:0] ev = 7'h00;
  logic dlb = 1'b0;
  logic pin_n;
  logic awready, wready, bvalid, arready, rvalid, pwr, cken, srst, inh, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0;
  int n_checks = 0;

  // 25 MHz reference clock
  always #20 clk = ~clk;

  sdcbs_card_model card (.clk_i(clk), .pin_n_o(pin_n));

  sdcbs_top dut (
    .REF_CLK_I(clk), .RESET_N_I(rst_n),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
    .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
    .CARD_DETECT_PIN_N_I(pin_n), .XFER_RD_CMD_END_I(ev[0]), .XFER_LAST_BLOCK_I(ev[1]),
    .XFER_GAP_IDLE_I(ev[2]), .DATA_LINE_BUSY_I(dlb), .BUF_RD_FULL_I(ev[3]),
    .BUF_RD_DRAINED_I(ev[4]), .BUF_WR_SPACE_I(ev[5]), .BUF_WR_FILLED_I(ev[6]),
    .CARD_BUS_POWER_O(pwr), .CARD_CLOCK_EN_O(cken), .FULL_SW_RESET_O(srst),
    .DATA_CMD_INHIBIT_O(inh), .IRQ_O(irq)
  );

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // Write master: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Bus helpers that also judge the response code, and for reads the data
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk32({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk32(d, ed);
    chk32({30'h0, r}, {30'h0, er});
  endtask

  // One-cycle pulse on a transfer or buffer event input, then let flags settle
  task automatic pulse(input int i);
    ev <= 7'h01 << i;
    @(posedge clk);
    ev <= 7'h00;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    rd_chk(8'h24, 32'h0, 2'h0);
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h34, 32'h0, 2'h0);
    rd_chk(8'h08, 32'h0, 2'h2);
    wr_chk(8'h08, 32'h1, 2'h2);
    wr_chk(8'h24, 32'hffff_ffff, 2'h2);
    chk1(irq, 1'b0);
    wr_chk(8'h34, 32'h1f, 2'h0);
    rd_chk(8'h34, 32'h1f, 2'h0);
    // A write without its low byte lane must leave the mask alone
    wstrb <= 4'h0;
    wr_chk(8'h34, 32'h00, 2'h0);
    wstrb <= 4'hf;
    rd_chk(8'h34, 32'h1f, 2'h0);
    $display("test reset done");
  endtask

  // Insertion with bus power off must still be seen
  task automatic t_insert();
    card.move(1'b0);
    chk1(pwr, 1'b0);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    chk1(irq, 1'b1);
    rd_chk(8'h30, 32'h01, 2'h0);
    repeat (3) @(posedge clk);
    chk1(irq, 1'b0);
    rd_chk(8'h30, 32'h00, 2'h0);
    $display("test insert done");
  endtask

  task automatic t_buffers();
    pulse(3);
    rd_chk(8'h24, 32'h0007_0800, 2'h0);
    rd_chk(8'h30, 32'h04, 2'h0);
    pulse(4);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    pulse(5);
    rd_chk(8'h24, 32'h0007_0400, 2'h0);
    rd_chk(8'h30, 32'h08, 2'h0);
    pulse(6);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    wr_chk(8'h34, 32'h00, 2'h0);
    pulse(3);
    chk1(irq, 1'b0);
    rd_chk(8'h30, 32'h04, 2'h0);
    pulse(4);
    wr_chk(8'h34, 32'h1f, 2'h0);
    $display("test buffers done");
  endtask

  task automatic t_xfer();
    pulse(0);
    rd_chk(8'h24, 32'h0007_0202, 2'h0);
    chk1(inh, 1'b1);
    pulse(1);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    rd_chk(8'h30, 32'h10, 2'h0);
    wr_chk(8'h04, 32'h02, 2'h0);
    rd_chk(8'h24, 32'h0007_0202, 2'h0);
    wr_chk(8'h04, 32'h01, 2'h0);
    rd_chk(8'h04, 32'h01, 2'h0);
    pulse(2);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    rd_chk(8'h30, 32'h10, 2'h0);
    wr_chk(8'h04, 32'h00, 2'h0);
    dlb <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h24, 32'h0007_0006, 2'h0);
    dlb <= 1'b0;
    repeat (3) @(posedge clk);
    chk1(inh, 1'b0);
    rd_chk(8'h30, 32'h10, 2'h0);
    $display("test transfer done");
  endtask

  // Live removal: power, clock and full software reset must all drop
  task automatic t_removal();
    wr_chk(8'h00, 32'h07, 2'h0);
    chk1(pwr, 1'b1);
    rd_chk(8'h24, 32'h0007_0000, 2'h0);
    card.move(1'b1);
    chk1(pwr, 1'b0);
    chk1(cken, 1'b0);
    chk1(srst, 1'b0);
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h24, 32'h0002_0000, 2'h0);
    rd_chk(8'h30, 32'h02, 2'h0);
    $display("test removal done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well past the two settle intervals and bus traffic
  initial begin
    #(40 * 20000);
    failures++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_insert();
    t_buffers();
    t_xfer();
    t_removal();
    finish_test();
  end
endmodule
